// File: core/qdsc_decoder.v
// Serial command decoder for a four-channel 12-bit converter
`include "qdsc_defs.vh"
module qdsc_decoder #(
  parameter NUM_CH = 4,
  parameter CODE_W = 12
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Serial link
  input wire sclk_i,
  input wire sdin_i,
  input wire sync_n_i,
  // Per-channel active state, channel A in the lowest slice
  output reg [NUM_CH*CODE_W-1:0] dac_code_o,
  output reg [NUM_CH*2-1:0] dac_pd_mode_o,
  // Reference state
  output reg [1:0] ref_mode_o,
  output reg ref_enable_o,
  // One-cycle pulse when a complete frame is acted on
  output reg frame_done_o
);

  ////////////////////////////////////////////////////////////////////////
  reg [2:0] sclk_sync_ff;
  reg [1:0] sdin_sync_ff;
  reg [1:0] sync_n_sync_ff;
  reg [`QDSC_FRAME_BITS-1:0] shift_ff;
  reg [4:0] cnt_ff;
  reg [NUM_CH*CODE_W-1:0] buf_code_ff;
  reg [NUM_CH*2-1:0] buf_pd_ff;

  // Third stage only feeds the edge detector, never the first stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync_ff <= 3'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_i};
    end
  end

  // Data is only ever read from the second stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdin_sync_ff <= 2'h0;
    end else begin
      sdin_sync_ff <= {sdin_sync_ff[0], sdin_i};
    end
  end

  // Resets idle high, so leaving reset never looks like a frame start
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_n_sync_ff <= 2'h3;
    end else begin
      sync_n_sync_ff <= {sync_n_sync_ff[0], sync_n_i};
    end
  end

  wire sclk_fall = sclk_sync_ff[2] & ~sclk_sync_ff[1];
  wire frame_act = ~sync_n_sync_ff[1];
  wire shift_en = frame_act & sclk_fall & (cnt_ff != `QDSC_FRAME_BITS);
  wire [`QDSC_FRAME_BITS-1:0] nxt_shift = {shift_ff[`QDSC_FRAME_BITS-2:0], sdin_sync_ff[1]};
  // Frame acts on the edge that brings in its 24th bit
  wire frame_fire = shift_en & (cnt_ff == (`QDSC_FRAME_BITS - 1));

  ////////////////////////////////////////////////////////////////////////
  // Bit counter: restarts whenever frame select goes inactive, so an
  // aborted or glitched frame is simply dropped
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_ff <= {`QDSC_FRAME_BITS{1'b0}};
      cnt_ff <= `QDSC_CNT_RST;
    end else if (!frame_act) begin
      cnt_ff <= `QDSC_CNT_RST;
    end else if (shift_en) begin
      shift_ff <= nxt_shift;
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wire ld_all = nxt_shift[`QDSC_LOAD_ALL_POS];
  wire ld_one = nxt_shift[`QDSC_LOAD_SINGLE_POS];
  wire [1:0] sel = nxt_shift[`QDSC_SEL_HI:`QDSC_SEL_LO];
  wire pd_flag = nxt_shift[`QDSC_PD_FLAG_POS];
  wire [1:0] pd_mode = nxt_shift[`QDSC_PD_MODE_HI:`QDSC_PD_MODE_LO];
  wire [1:0] ref_cmd = nxt_shift[`QDSC_REF_HI:`QDSC_REF_LO];
  wire [CODE_W-1:0] code = nxt_shift[`QDSC_CODE_HI:`QDSC_CODE_LO];
  wire bcast = ld_all & ld_one & (sel == `QDSC_SEL_BCAST);
  wire ref_cmd_hit = pd_flag & ~ld_all & ~ld_one & (sel == 2'h0) &
                     (pd_mode == `QDSC_PD_NORMAL);
  // Load bits 11 with another select act as a single-channel load
  wire load_one = ld_one & ~bcast;
  wire load_all = ld_all & ~ld_one;

  // Channel decode shared by the buffer write and the load paths
  function qdsc_sel_hit;
    input [1:0] sel_f;
    input integer idx;
    begin
      qdsc_sel_hit = (sel_f == idx[1:0]);
    end
  endfunction

  // True when no channel is left in normal operation
  function qdsc_all_pd;
    input [NUM_CH*2-1:0] modes;
    integer k;
    begin
      qdsc_all_pd = 1'b1;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        if (modes[k*2 +: 2] == `QDSC_PD_NORMAL) begin
          qdsc_all_pd = 1'b0;
        end
      end
    end
  endfunction

  // Per-channel next state
  reg [NUM_CH*CODE_W-1:0] nxt_buf_code;
  reg [NUM_CH*2-1:0] nxt_buf_pd;
  reg [NUM_CH*CODE_W-1:0] nxt_code;
  reg [NUM_CH*2-1:0] nxt_pd;
  reg all_down;
  integer i;
  always @* begin
    nxt_buf_code = buf_code_ff;
    nxt_buf_pd = buf_pd_ff;
    nxt_code = dac_code_o;
    nxt_pd = dac_pd_mode_o;
    for (i = 0; i < NUM_CH; i = i + 1) begin
      if (!ref_cmd_hit && (bcast || qdsc_sel_hit(sel, i))) begin
        // Power-down leaves the buffered code intact
        if (pd_flag) begin
          nxt_buf_pd[i*2 +: 2] = pd_mode;
        end else begin
          nxt_buf_code[i*CODE_W +: CODE_W] = code;
          nxt_buf_pd[i*2 +: 2] = `QDSC_PD_NORMAL;
        end
      end
    end
    for (i = 0; i < NUM_CH; i = i + 1) begin
      if (!ref_cmd_hit && (load_all || bcast || (load_one && qdsc_sel_hit(sel, i)))) begin
        nxt_code[i*CODE_W +: CODE_W] = nxt_buf_code[i*CODE_W +: CODE_W];
        nxt_pd[i*2 +: 2] = nxt_buf_pd[i*2 +: 2];
      end
    end
    all_down = qdsc_all_pd(nxt_pd);
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference control; a reserved command code leaves everything as it was
  reg [1:0] nxt_ref_mode;
  reg nxt_ref_enable;
  always @* begin
    nxt_ref_mode = ref_mode_o;
    nxt_ref_enable = ref_enable_o;
    if (ref_cmd_hit) begin
      case (ref_cmd)
        `QDSC_REF_ON: begin
          nxt_ref_mode = `QDSC_REF_ON;
          nxt_ref_enable = 1'b1;
        end
        `QDSC_REF_OFF: begin
          nxt_ref_mode = `QDSC_REF_OFF;
          nxt_ref_enable = 1'b0;
        end
        `QDSC_REF_AUTO: begin
          // Judged from the channels at once, not deferred to the next frame
          nxt_ref_mode = `QDSC_REF_AUTO;
          nxt_ref_enable = ~all_down;
        end
        default: begin
          nxt_ref_mode = ref_mode_o;
        end
      endcase
    end else if (ref_mode_o == `QDSC_REF_AUTO) begin
      nxt_ref_enable = ~all_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_code_ff <= {NUM_CH{`QDSC_CODE_RST}};
      buf_pd_ff <= {NUM_CH*2{1'b0}};
      dac_code_o <= {NUM_CH{`QDSC_CODE_RST}};
      dac_pd_mode_o <= {NUM_CH*2{1'b0}};
      ref_mode_o <= `QDSC_REF_AUTO;
      ref_enable_o <= 1'b1;
      frame_done_o <= 1'b0;
    end else begin
      frame_done_o <= frame_fire;
      if (frame_fire) begin
        buf_code_ff <= nxt_buf_code;
        buf_pd_ff <= nxt_buf_pd;
        dac_code_o <= nxt_code;
        dac_pd_mode_o <= nxt_pd;
        // Reference state moves with the frame that carried the command
        ref_mode_o <= nxt_ref_mode;
        ref_enable_o <= nxt_ref_enable;
      end
    end
  end

endmodule

// File: core/qdsc_defs.vh
// Frame field positions, encodings and reset values for the quad converter command decoder
`ifndef QDSC_DEFS_VH
`define QDSC_DEFS_VH
`define QDSC_FRAME_BITS 24
`define QDSC_LOAD_ALL_POS 21
`define QDSC_LOAD_SINGLE_POS 20
`define QDSC_SEL_HI 18
`define QDSC_SEL_LO 17
`define QDSC_PD_FLAG_POS 16
`define QDSC_PD_MODE_HI 15
`define QDSC_PD_MODE_LO 14
`define QDSC_REF_HI 13
`define QDSC_REF_LO 12
`define QDSC_CODE_HI 15
`define QDSC_CODE_LO 4
`define QDSC_SEL_BCAST 2'h2
`define QDSC_PD_NORMAL 2'h0
`define QDSC_PD_1K 2'h1
`define QDSC_PD_100K 2'h2
`define QDSC_PD_HIZ 2'h3
`define QDSC_REF_AUTO 2'h0
`define QDSC_REF_ON 2'h1
`define QDSC_REF_OFF 2'h2
`define QDSC_CODE_RST 12'h000
`define QDSC_CNT_RST 5'h00
`endif

// File: sim/qdsc_decoder_props.sv
// Port checks for the serial command decoder
module qdsc_decoder_props #(parameter NUM_CH = 4, parameter CODE_W = 12) (
  // Clock, reset and link
  input wire clk_i, rst_i, sclk_i, sdin_i, sync_n_i,
  // Channel and reference state
  input wire [NUM_CH*CODE_W-1:0] dac_code_o,
  input wire [NUM_CH*2-1:0] dac_pd_mode_o,
  input wire [1:0] ref_mode_o,
  input wire ref_enable_o, frame_done_o
);
  wire all_dn = |dac_pd_mode_o[1:0] & |dac_pd_mode_o[3:2] & |dac_pd_mode_o[5:4]
    & |dac_pd_mode_o[7:6];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet; !frame_done_o [*8]; endsequence
  property p_gap; frame_done_o |=> s_quiet; endproperty
  a_gap: assert property (p_gap) else $error("frames too close");
  property p_code; !frame_done_o |-> $stable(dac_code_o); endproperty
  a_code: assert property (p_code) else $error("stray code change");
  property p_pd; !frame_done_o |-> $stable(dac_pd_mode_o); endproperty
  a_pd: assert property (p_pd) else $error("stray mode change");
  property p_ref; !frame_done_o |-> $stable({ref_mode_o, ref_enable_o}); endproperty
  a_ref: assert property (p_ref) else $error("stray reference change");
  property p_on; ref_mode_o == 2'h1 |-> ref_enable_o; endproperty
  a_on: assert property (p_on) else $error("forced on but off");
  property p_off; ref_mode_o == 2'h2 |-> !ref_enable_o; endproperty
  a_off: assert property (p_off) else $error("forced off but on");
  property p_auto_dn; ref_mode_o == 2'h0 && all_dn |-> !ref_enable_o; endproperty
  a_auto_dn: assert property (p_auto_dn) else $error("reference left up");
  property p_auto_up; ref_mode_o == 2'h0 && !all_dn |-> ref_enable_o; endproperty
  a_auto_up: assert property (p_auto_up) else $error("reference left down");
  property p_edge; frame_done_o |-> !sclk_i; endproperty
  a_edge: assert property (p_edge) else $error("update off a falling edge");
endmodule
bind qdsc_decoder qdsc_decoder_props #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) qdsc_decoder_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sdin_i(sdin_i), .sync_n_i(sync_n_i),
  .dac_code_o(dac_code_o), .dac_pd_mode_o(dac_pd_mode_o), .ref_mode_o(ref_mode_o),
  .ref_enable_o(ref_enable_o), .frame_done_o(frame_done_o));

// File: sim/qdsc_decoder_tb.sv
// Self-checking bench for the serial command decoder
module qdsc_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk_i, sdin_i, sync_n_i, ref_enable_o, frame_done_o;
  logic [47:0] dac_code_o;
  logic [7:0] dac_pd_mode_o;
  logic [1:0] ref_mode_o;
  logic [47:0] ec = 48'h0000_0000_0000;
  logic [7:0] ep = 8'h00;
  logic [1:0] er = 2'h0;
  logic ee = 1'b1;
  int done_cnt = 0, ed = 0, fail_count = 0, num_checks = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (frame_done_o === 1'b1) done_cnt++;
  qdsc_host qdsc_host_inst (.clk_i(clk_i), .sclk_o(sclk_i), .sdin_o(sdin_i), .sync_n_o(sync_n_i));
  qdsc_decoder qdsc_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sdin_i(sdin_i),
    .sync_n_i(sync_n_i), .dac_code_o(dac_code_o), .dac_pd_mode_o(dac_pd_mode_o),
    .ref_mode_o(ref_mode_o), .ref_enable_o(ref_enable_o), .frame_done_o(frame_done_o));
  ////////////////////////////////////////
  function automatic logic [23:0] fr(input logic [1:0] ld, sel, input logic pd, logic [11:0] d);
    return {2'b00, ld, 1'b0, sel, pd, d, 4'hA};
  endfunction
  task automatic chk();
    num_checks++;
    if ({dac_code_o, dac_pd_mode_o, ref_mode_o, ref_enable_o, done_cnt} !== {ec, ep, er, ee, ed}) begin
      fail_count++;
      $display("mismatch at %0t: state %h %h %h %b", $time, dac_code_o, dac_pd_mode_o,
        ref_mode_o, ref_enable_o);
    end
  endtask
  task automatic go(input logic [23:0] f);
    qdsc_host_inst.send(f);
    ed++;
    chk();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #200_000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk();
    for (int c = 0; c < 4; c++) go(fr(2'h0, c[1:0], 1'b0, {10'h040, c[1:0]}));
    ec = {12'hABC, 12'h102, 12'h101, 12'h100};
    go(fr(2'h2, 2'h3, 1'b0, 12'hABC));
    ep = 8'h04;
    go(fr(2'h1, 2'h1, 1'b1, 12'h7FF));
    go(fr(2'h0, 2'h2, 1'b1, 12'hBFF));
    go(fr(2'h0, 2'h3, 1'b1, 12'hFFF));
    ep = 8'hE5;
    ee = 1'b0;
    go(fr(2'h2, 2'h0, 1'b1, 12'h4FF));
    ec[11:0] = 12'h777;
    ep[1:0] = 2'h0;
    ee = 1'b1;
    go(fr(2'h1, 2'h0, 1'b0, 12'h777));
    er = 2'h2;
    ee = 1'b0;
    go(fr(2'h0, 2'h0, 1'b1, 12'h200));
    ec = {4{12'h5A5}};
    ep = 8'h00;
    go(fr(2'h3, 2'h2, 1'b0, 12'h5A5));
    er = 2'h1;
    ee = 1'b1;
    go(fr(2'h0, 2'h0, 1'b1, 12'h100));
    ep = 8'hFF;
    go(fr(2'h3, 2'h2, 1'b1, 12'hFFF));
    er = 2'h0;
    ee = 1'b0;
    go(fr(2'h0, 2'h0, 1'b1, 12'h000));
    summarize();
  end
endmodule

// File: sim/qdsc_host.sv
// Host model that shifts 24-bit command frames into the decoder
module qdsc_host (
  // Clock
  input wire logic clk_i,
  // Serial link
  output logic sclk_o,
  output logic sdin_o,
  output logic sync_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    sdin_o = 1'b0;
    sync_n_o = 1'b1;
  end
  task automatic tick();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // Clock idles low, so the 24th fall is the last edge of a frame
  task automatic send(input logic [23:0] f);
    sync_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      tick();
      sclk_o = 1'b1;
      sdin_o = f[i];
      tick();
      sclk_o = 1'b0;
    end
    tick();
    sync_n_o = 1'b1;
    sdin_o = ~sdin_o;
    tick();
  endtask
endmodule
